//--- pst_port_cfg.sv
// Purpose: Per-port configuration registers of a dual port power switch
// Assumes: Register port driven by the management bus slave, one op a cycle
// Notes: Read data appear one cycle after i_reg_rd
//
// How it works
// - Registers keep contents through sleep state.
// - Join on: light load or regulation alerts.
// - Drain write opens switch; reads 1 meanwhile.
// - Switch on when pin OR software bit.
// - Drain selector gives 100 to 400 ms.
// - Detect level selects attach/removal thresholds.
// - Removal threshold differs, active versus detect.
`timescale 1ns/1ps
`default_nettype none
module pst_port_cfg #(
  parameter int STEP_CYCLES = pst_pkg::DRAIN_STEP_CYCLES
) (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  input wire logic [1:0] i_enable_pin,
  input wire logic [1:0] i_overvoltage_flag,
  input wire logic i_thermal_shutdown_flag,
  input wire logic [1:0] i_other_error,
  input wire logic [1:0] i_light_load_flag,
  input wire logic i_thermal_regulation_flag,
  input wire logic i_active_state,
  output logic [1:0] o_alert,
  output logic [1:0] o_switch_on,
  output logic [1:0] o_drain_active,
  output logic [3:0] o_detect_level,
  output logic [5:0] o_removal_sel
);
  // ****************************************************************
  // Register fields, index 0 is port 1
  // ****************************************************************
  logic [1:0] alert_filter;
  logic [1:0] next_alert_filter;
  logic [1:0] alert_join;
  logic [1:0] next_alert_join;
  logic [1:0] sw_switch_on;
  logic [1:0] next_sw_switch_on;
  logic [1:0] drain_duration_sel;
  logic [1:0] next_drain_duration_sel;
  logic [3:0] detect_level;
  logic [3:0] next_detect_level;
  logic [1:0] drain_busy;
  logic [1:0] drain_start;
  logic [7:0] next_rdata;
  logic [1:0] wr_hit;

  // Address decode shared by write and read paths
  function automatic logic [1:0] hit(input logic [7:0] addr);
    hit = {addr == pst_pkg::PORT2_CFG_ADDR, addr == pst_pkg::PORT1_CFG_ADDR};
  endfunction

  // Read image of one port register
  function automatic logic [7:0] image(input int p, input logic [1:0] dsel);
    image = 8'h00;
    image[pst_pkg::ALERT_FILTER_BIT] = alert_filter[p];
    image[pst_pkg::ALERT_JOIN_BIT] = alert_join[p];
    image[pst_pkg::FORCE_DRAIN_BIT] = drain_busy[p];
    image[pst_pkg::SW_SWITCH_ON_BIT] = sw_switch_on[p];
    image[pst_pkg::DRAIN_SEL_LSB +: 2] = dsel;
    image[pst_pkg::DETECT_LEVEL_LSB +: 2] = detect_level[2*p +: 2];
  endfunction

  assign wr_hit = i_reg_wr ? hit(i_reg_addr) : 2'b00;

  // ****************************************************************
  // Register writes and reads
  // ****************************************************************
  always_comb begin
    next_alert_filter = alert_filter;
    next_alert_join = alert_join;
    next_sw_switch_on = sw_switch_on;
    next_drain_duration_sel = drain_duration_sel;
    next_detect_level = detect_level;
    drain_start = 2'b00;
    for (int p = 0; p < 2; p++) begin
      if (wr_hit[p]) begin
        next_alert_filter[p] = i_reg_wdata[pst_pkg::ALERT_FILTER_BIT];
        next_alert_join[p] = i_reg_wdata[pst_pkg::ALERT_JOIN_BIT];
        next_sw_switch_on[p] = i_reg_wdata[pst_pkg::SW_SWITCH_ON_BIT];
        next_detect_level[2*p +: 2] =
          i_reg_wdata[pst_pkg::DETECT_LEVEL_LSB +: 2];
        // Writing 1 starts a drain unless one is running, 0 has no effect
        drain_start[p] = i_reg_wdata[pst_pkg::FORCE_DRAIN_BIT] &
          ~drain_busy[p];
      end
    end
    if (wr_hit[0]) begin
      next_drain_duration_sel =
        i_reg_wdata[pst_pkg::DRAIN_SEL_LSB +: 2];
    end
    next_rdata = 8'h00;
    if (i_reg_rd) begin
      unique case (hit(i_reg_addr))
        2'b01: next_rdata = image(0, drain_duration_sel);
        2'b10: next_rdata = image(1, 2'b00);
        default: next_rdata = 8'h00; // Unmapped reads zero
      endcase
    end
  end

  // Only the chip reset clears these, sleep never does
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      alert_filter <= 2'b00;
      alert_join <= 2'b00;
      sw_switch_on <= 2'b00;
      drain_duration_sel <= pst_pkg::PORT1_CFG_RESET[3:2];
      detect_level <= {pst_pkg::PORT2_CFG_RESET[1:0],
        pst_pkg::PORT1_CFG_RESET[1:0]};
      o_reg_rdata <= 8'h00;
    end else begin
      alert_filter <= next_alert_filter;
      alert_join <= next_alert_join;
      sw_switch_on <= next_sw_switch_on;
      drain_duration_sel <= next_drain_duration_sel;
      detect_level <= next_detect_level;
      o_reg_rdata <= next_rdata;
    end
  end

  // ****************************************************************
  // Drain timers, one per port
  // ****************************************************************
  for (genvar g = 0; g < 2; g++) begin : g_drain
    pst_drain_if drain_bus ();
    assign drain_bus.start = drain_start[g];
    // Selector as it will be after this cycle's write, so a write
    // that sets both the selector and the drain bit uses the new time
    assign drain_bus.step_sel = next_drain_duration_sel;
    assign drain_busy[g] = drain_bus.busy;
    pst_drain_timer #(.STEP_CYCLES(STEP_CYCLES)) u_timer (
      .i_mclk(i_mclk),
      .i_reset_n(i_reset_n),
      .drain(drain_bus.timer)
    );
  end

  // ****************************************************************
  // Enable pin synchroniser, three stages, counted when 2 and 3 agree
  // ****************************************************************
  logic [1:0] en_s1;
  logic [1:0] en_s2;
  logic [1:0] en_s3;
  logic [1:0] en_pin;
  logic [1:0] next_en_pin;
  assign next_en_pin = (en_s2 & en_s3) | (en_pin & (en_s2 | en_s3));
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      en_s1 <= 2'b00;
      en_s2 <= 2'b00;
      en_s3 <= 2'b00;
      en_pin <= 2'b00;
    end else begin
      en_s1 <= i_enable_pin;
      en_s2 <= en_s1;
      en_s3 <= en_s2;
      en_pin <= next_en_pin;
    end
  end

  // ****************************************************************
  // Outputs to switch, fault and detection logic
  // ****************************************************************
  logic [1:0] next_alert;
  logic [1:0] next_switch_on;
  logic [5:0] next_removal_sel;
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      next_alert[p] = i_overvoltage_flag[p] | i_thermal_shutdown_flag |
        (~alert_filter[p] & i_other_error[p]) |
        (alert_join[p] & (i_light_load_flag[p] |
        i_thermal_regulation_flag));
      next_switch_on[p] = (en_pin[p] | sw_switch_on[p]) &
        ~drain_busy[p];
      next_removal_sel[3*p +: 3] =
        {i_active_state, detect_level[2*p +: 2]};
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_alert <= 2'b00;
      o_switch_on <= 2'b00;
      o_drain_active <= 2'b00;
      o_removal_sel <= 6'h00;
    end else begin
      o_alert <= next_alert;
      o_switch_on <= next_switch_on;
      o_drain_active <= drain_busy;
      o_removal_sel <= next_removal_sel;
    end
  end
  assign o_detect_level = detect_level;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);

  cfg_retained_a: assert property (
    !wr_hit[0] |=> $stable(alert_filter[0]) && $stable(drain_duration_sel))
    else $error("port 1 setting changed without a write");
  filter_alert_a: assert property (
    (alert_filter[0] && !i_overvoltage_flag[0] && !i_thermal_shutdown_flag
     && !alert_join[0]) |=> !o_alert[0])
    else $error("filtered alert raised by other error");
  unfiltered_alert_a: assert property (
    (!alert_filter[1] && i_other_error[1]) |=> o_alert[1])
    else $error("unfiltered error did not alert");
  join_alert_a: assert property (
    (alert_join[0] && i_thermal_regulation_flag) |=> o_alert[0])
    else $error("joined indicator did not alert");
  drain_opens_a: assert property (
    drain_start[1] |=> ##1 (!o_switch_on[1] && o_drain_active[1]))
    else $error("drain did not open switch");
  drain_read_a: assert property (
    (i_reg_rd && i_reg_addr == pst_pkg::PORT1_CFG_ADDR && drain_busy[0])
    |=> o_reg_rdata[pst_pkg::FORCE_DRAIN_BIT])
    else $error("drain bit read 0 while draining");
  switch_resume_a: assert property (
    ($fell(drain_busy[0]) && sw_switch_on[0] && !wr_hit[0]) |=> o_switch_on[0])
    else $error("switch did not resume after drain");
  switch_or_a: assert property (
    (en_pin[1] && !drain_busy[1]) |=> o_switch_on[1])
    else $error("enable pin did not turn switch on");
  removal_mode_a: assert property (
    1'b1 |=> o_removal_sel[2] == $past(i_active_state))
    else $error("removal threshold ignores power state");
  level_write_a: assert property (
    wr_hit[1] |=> o_detect_level[3:2] == $past(i_reg_wdata[1:0]))
    else $error("detect level not written");

  drain_cov: cover property (drain_start[0] ##1 drain_busy[0]);
  alert_cov: cover property (alert_join[1] && o_alert[1]);
  switch_cov: cover property (o_switch_on == 2'b11);
endmodule
`default_nettype wire

//--- pst_pkg.sv
// Purpose: Shared constants for the port switch configuration registers
// Assumes: 125 MHz core clock
// Notes: Offsets are register addresses on the internal register port
package pst_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] PORT1_CFG_ADDR = 8'h11;
  localparam logic [7:0] PORT2_CFG_ADDR = 8'h14;
  localparam logic [7:0] PORT1_CFG_RESET = 8'h06;
  localparam logic [7:0] PORT2_CFG_RESET = 8'h02;
  // ****************************************************************
  // Field positions, same for both ports except the drain selector, which exists on port 1 only
  // ****************************************************************
  localparam int ALERT_FILTER_BIT = 7;
  localparam int ALERT_JOIN_BIT = 6;
  localparam int FORCE_DRAIN_BIT = 5;
  localparam int SW_SWITCH_ON_BIT = 4;
  localparam int DRAIN_SEL_LSB = 2;
  localparam int DETECT_LEVEL_LSB = 0;
  // ****************************************************************
  // Timing: one drain step is 100 ms, selector adds whole steps
  // ****************************************************************
  localparam int CLK_KHZ = 125_000;
  localparam int DRAIN_STEP_MS = 100;
  localparam int DRAIN_STEP_CYCLES = DRAIN_STEP_MS * CLK_KHZ;
endpackage

//--- pst_drain_if.sv
// Purpose: Carries a drain request and status between control and timer
// Assumes: Single clock domain
// Notes: start is a one-cycle request, busy is a registered level
`timescale 1ns/1ps
`default_nettype none
interface pst_drain_if;
  logic start;
  logic [1:0] step_sel;
  logic busy;
  modport ctrl (output start, output step_sel, input busy);
  modport timer (input start, input step_sel, output busy);
endinterface
`default_nettype wire

//--- pst_drain_timer.sv
// Purpose: Times one bus drain of (step_sel + 1) drain steps
// Assumes: start is only raised while busy is low
// Notes: STEP_CYCLES may be shortened for simulation
`timescale 1ns/1ps
`default_nettype none
module pst_drain_timer #(
  parameter int STEP_CYCLES = pst_pkg::DRAIN_STEP_CYCLES
) (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  pst_drain_if.timer drain
);
  logic [23:0] pre;
  logic [23:0] next_pre;
  logic [1:0] steps;
  logic [1:0] next_steps;
  logic busy;
  logic next_busy;
  localparam logic [23:0] STEP_LAST = 24'(STEP_CYCLES - 1);

  // ****************************************************************
  // Step prescaler and remaining-step count
  // ****************************************************************
  always_comb begin
    next_pre = pre;
    next_steps = steps;
    next_busy = busy;
    if (!busy && drain.start) begin
      next_busy = 1'b1;
      next_steps = drain.step_sel;
      next_pre = 24'h00_0000;
    end else if (busy) begin
      if (pre == STEP_LAST) begin
        next_pre = 24'h00_0000;
        if (steps == 2'h0) begin
          next_busy = 1'b0;
        end else begin
          next_steps = steps - 2'h1;
        end
      end else begin
        next_pre = pre + 24'h00_0001;
      end
    end
  end

  // Registers only
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pre <= 24'h00_0000;
      steps <= 2'h0;
      busy <= 1'b0;
    end else begin
      pre <= next_pre;
      steps <= next_steps;
      busy <= next_busy;
    end
  end

  assign drain.busy = busy;

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Busy span measured in cycles
  logic [26:0] span;
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      span <= 27'h000_0000;
    end else if (busy) begin
      span <= span + 27'h000_0001;
    end else begin
      span <= 27'h000_0000;
    end
  end
  logic [1:0] sel_held;
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sel_held <= 2'h0;
    end else if (!busy && drain.start) begin
      sel_held <= drain.step_sel;
    end
  end
  drain_length_a: assert property (
    @(posedge i_mclk) disable iff (!i_reset_n)
    $fell(busy) |-> span == 27'((sel_held + 3'h1) * STEP_CYCLES))
    else $error("drain span does not match selector");
  drain_starts_a: assert property (
    @(posedge i_mclk) disable iff (!i_reset_n)
    (!busy && drain.start) |=> busy)
    else $error("drain did not start");
  drain_end_cov: cover property (
    @(posedge i_mclk) disable iff (!i_reset_n) $fell(busy));
endmodule
`default_nettype wire

//--- pst_host_model.sv
// Purpose: Management host model driving the register port
// Assumes: One request at a time, strobes one cycle long
// Notes: Released address and data lines show the inverse value
`timescale 1ns/1ps
`default_nettype none
module pst_host_model (
  input wire logic i_mclk,
  output logic [7:0] o_reg_addr,
  output logic o_reg_wr,
  output logic [7:0] o_reg_wdata,
  output logic o_reg_rd
);
  // Expected read data, oldest first
  logic [7:0] exp_q[$];

  // Idle bus at time zero
  initial begin
    o_reg_addr = 8'h00;
    o_reg_wr = 1'b0;
    o_reg_wdata = 8'h00;
    o_reg_rd = 1'b0;
  end

  // ****************************************************************
  // Register port cycles
  // ****************************************************************
  // One write strobe, then lines released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    o_reg_addr <= a;
    o_reg_wdata <= d;
    o_reg_wr <= 1'b1;
    @(posedge i_mclk);
    o_reg_wr <= 1'b0;
    o_reg_addr <= ~a;
    o_reg_wdata <= ~d;
  endtask

  // One read strobe, expected data noted
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_mclk);
    o_reg_addr <= a;
    o_reg_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge i_mclk);
    o_reg_rd <= 1'b0;
    o_reg_addr <= ~a;
  endtask
endmodule
`default_nettype wire

//--- tb_top.sv
// Purpose: Self-checking bench for the port switch config registers
// Assumes: Drain step shortened to 20 cycles
// Notes: Read data checked by a monitor against a queue of notes
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int STEP = 20;
  localparam logic [7:0] A1 = pst_pkg::PORT1_CFG_ADDR;
  localparam logic [7:0] A2 = pst_pkg::PORT2_CFG_ADDR;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v, addr;
  logic reg_wr, reg_rd, thermal_shutdown_flag = 1'b0, thermal_regulation_flag = 1'b0, active = 1'b0;
  logic rd_seen = 1'b0, exp_alert, in_span;
  logic [1:0] pin = 2'b00, ov = 2'b00, oth = 2'b00, light = 2'b00;
  logic [1:0] alert, switch_on, drain, sel;
  logic [3:0] detect_level;
  logic [5:0] removal_sel;
  logic [15:0] seed = 16'h7b3c;
  int errors = 0, check_count = 0, dcnt = 0, p, k, c, a, s, t;

  // ****************************************************************
  // Clock, instances, monitor
  // ****************************************************************
  always #4 mclk = ~mclk;

  pst_host_model host (.i_mclk(mclk), .o_reg_addr(reg_addr),
    .o_reg_wr(reg_wr), .o_reg_wdata(reg_wdata), .o_reg_rd(reg_rd));

  pst_port_cfg #(.STEP_CYCLES(STEP)) uut (.i_mclk(mclk),
    .i_reset_n(reset_n), .i_reg_addr(reg_addr), .i_reg_wr(reg_wr),
    .i_reg_wdata(reg_wdata), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata),
    .i_enable_pin(pin), .i_overvoltage_flag(ov),
    .i_thermal_shutdown_flag(thermal_shutdown_flag), .i_other_error(oth),
    .i_light_load_flag(light), .i_thermal_regulation_flag(thermal_regulation_flag),
    .i_active_state(active), .o_alert(alert), .o_switch_on(switch_on),
    .o_drain_active(drain), .o_detect_level(detect_level),
    .o_removal_sel(removal_sel));

  // Read data compared one cycle after the strobe is taken
  always @(posedge mclk) begin
    if (rd_seen && host.exp_q.size() > 0) begin
      check(reg_rdata, host.exp_q.pop_front());
    end
    rd_seen <= reg_rd;
  end

  // Drain length counter, cleared by a write
  always @(posedge mclk) begin
    dcnt <= (drain != 2'b00) ? dcnt + 1 : (reg_wr ? 0 : dcnt);
  end

  // Hang guard
  initial begin
    #(8 * 30000);
    errors++;
    final_report();
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  function automatic logic [15:0] lfsr_next(input logic [15:0] q);
    return {q[14:0], q[15] ^ q[13] ^ q[12] ^ q[10]};
  endfunction

  function automatic logic [1:0] at(input int n, input logic b);
    return b ? (n != 0 ? 2'b10 : 2'b01) : 2'b00;
  endfunction

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    tick(1);
    check(detect_level, 4'b1010);
    host.rd(A1, pst_pkg::PORT1_CFG_RESET);
    host.rd(A2, pst_pkg::PORT2_CFG_RESET);
    host.rd(8'h12, 8'h00);
    // Random write and read back, drain bit left clear
    for (k = 0; k < 8; k++) begin
      seed = lfsr_next(seed);
      host.wr(A1, seed[7:0] & 8'hdf);
      host.rd(A1, seed[7:0] & 8'hdf);
      host.wr(A2, seed[15:8] & 8'hdf);
      host.rd(A2, seed[15:8] & 8'hd3);
    end
    // Threshold codes in both power states
    for (c = 0; c < 4; c++) begin
      host.wr(A1, {6'h00, c[1:0]});
      host.wr(A2, {6'h00, c[1:0]});
      for (a = 0; a < 2; a++) begin
        @(posedge mclk);
        active <= a[0];
        tick(2);
        check(detect_level, {c[1:0], c[1:0]});
        check(removal_sel, {a[0], c[1:0], a[0], c[1:0]});
      end
    end
    // Pin OR software enable
    for (p = 0; p < 2; p++) begin
      for (k = 0; k < 4; k++) begin
        host.wr(p != 0 ? A2 : A1, {3'b000, k[1], 4'h0});
        @(posedge mclk);
        pin[p] <= k[0];
        tick(7);
        check(switch_on[p], k[0] | k[1]);
      end
    end
    // Full alert truth table per port
    for (p = 0; p < 2; p++) begin
      for (k = 0; k < 128; k++) begin
        host.wr(p != 0 ? A2 : A1, {k[6], k[5], 6'h00});
        @(posedge mclk);
        ov <= at(p, k[4]);
        thermal_shutdown_flag <= k[3];
        oth <= at(p, k[2]);
        light <= at(p, k[1]);
        thermal_regulation_flag <= k[0];
        tick(2);
        exp_alert = k[4] | k[3] | (!k[6] & k[2]) | (k[5] & (k[1] | k[0]));
        check(alert[p], exp_alert);
      end
    end
    // Forced drain: four durations on port 1, longest on port 2
    for (s = 0; s < 5; s++) begin
      p = (s == 4) ? 1 : 0;
      sel = (s == 4) ? 2'b11 : s[1:0];
      addr = (p != 0) ? A2 : A1;
      v = {4'h3, sel, 2'b00};
      if (p != 0) begin
        host.wr(A1, {4'h0, sel, 2'b00});
        v = 8'h20;
      end
      host.wr(addr, v);
      tick(3);
      check(drain[p], 1'b1);
      check(switch_on[p], 1'b0);
      host.rd(addr, v);
      // Second drain write while draining must not restart the timer
      host.wr(addr, v);
      t = 0;
      while (drain[p] === 1'b1 && t < 600) begin
        tick(1);
        t++;
      end
      in_span = dcnt >= (sel + 1) * STEP - 2 && dcnt <= (sel + 1) * STEP + 2;
      check(in_span, 1'b1);
      tick(2);
      check(switch_on[p], 1'b1);
      host.rd(addr, v & 8'hdf);
    end
    host.rd(A1, 8'h0c);
    tick(4);
    final_report();
  end
endmodule
`default_nettype wire
